// *** rtl/gsc_gain_if.sv ***
// carrier between the search and the gain quantizer
`default_nettype none
interface gsc_gain_if;
   import gsc_pkg::*;
   gsc_acc_type                  corr;
   logic        [ACC_W-1:0]      energy;
   logic                         signBit;
   logic        [GAIN_IDX_W-1:0] index;
   gsc_sample_type               magnitude;
   modport quant (input corr, energy, output signBit, index, magnitude);
   modport user  (output corr, energy, input signBit, index, magnitude);
endinterface
`default_nettype wire

// *** rtl/gsc_gain_quant.sv ***
// glottal gain sign and index quantizer
`default_nettype none
module gsc_gain_quant (
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   gsc_gain_if.quant gain
);
   import gsc_pkg::*;

   logic [QNT_W-1:0]      absCorr;
   logic [QNT_W-1:0]      denom;
   logic [GAIN_IDX_W-1:0] idx_d;

   always_comb begin
      absCorr = gain.corr[ACC_W-1] ? QNT_W'(-gain.corr) : QNT_W'(gain.corr);
      absCorr = absCorr << COEF_FRAC;
      denom   = QNT_W'(gain.energy) + QNT_W'(ENERGY_EPS);
      idx_d   = '0;
      // largest entry still below the magnitude; none below keeps 0
      for (int i = 0; i < GAIN_ENTRIES; i++) begin
         if (QNT_W'(GSC_GAIN_TABLE[i]) * denom < absCorr)
            idx_d = GAIN_IDX_W'(i);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         gain.signBit   <= 1'b1;
         gain.index     <= '0;
         gain.magnitude <= '0;
      end else begin
         gain.signBit   <= ~gain.corr[ACC_W-1];
         gain.index     <= idx_d;
         gain.magnitude <= GSC_GAIN_TABLE[idx_d];
      end
   end
endmodule
`default_nettype wire

// *** rtl/gsc_pkg.sv ***
// constants, types and tables shared by the glottal-shape search
`default_nettype none
package gsc_pkg;
   localparam int SUB_LEN      = 64;
   localparam int IDX_W        = 6;
   localparam int NUM_SHAPES   = 8;
   localparam int SHAPE_W      = 3;
   localparam int SHAPE_LEN    = 17;
   localparam int HALF_LEN     = 8;
   localparam int SEARCH_SPAN  = 4;
   localparam int GAIN_ENTRIES = 8;
   localparam int GAIN_IDX_W   = 3;
   localparam int SAMPLE_W     = 16;
   localparam int COEF_FRAC    = 12;
   localparam int ZW           = 24;
   localparam int ACC_W        = 56;
   localparam int CMP_W        = 168;
   localparam int QNT_W        = 80;
   localparam int LAG_W        = 8;
   localparam int CNT_W        = 7;
   // shape prototype: peak and per-shape slope, arbitrary smooth pulses
   localparam int SHAPE_PEAK   = 4096;
   localparam int SHAPE_SLOPE  = 400;
   localparam int SHAPE_STEP   = 40;
   // 0.01 expressed at the Q24 scale of energies
   localparam logic [ACC_W-1:0] ENERGY_EPS = 56'h0000000028F5C;
   localparam logic [1:0] SEL_TARGET   = 2'h0;
   localparam logic [1:0] SEL_RESIDUAL = 2'h1;
   localparam logic [1:0] SEL_IMPULSE  = 2'h2;

   typedef logic signed [SAMPLE_W-1:0] gsc_sample_type;
   typedef logic signed [ACC_W-1:0]    gsc_acc_type;
   typedef logic signed [ZW-1:0]       gsc_row_type;

   // quantized gain magnitudes, Q12, ascending
   localparam gsc_sample_type GSC_GAIN_TABLE [GAIN_ENTRIES] = '{
      16'h0100, 16'h0200, 16'h0400, 16'h0600,
      16'h0800, 16'h0C00, 16'h1000, 16'h1800};

   typedef enum logic [3:0] {
      ST_IDLE, ST_PEAK, ST_ROW0, ST_ROWK, ST_CHECK, ST_SCORE, ST_CMP,
      ST_ADV, ST_TAILE, ST_TAILN, ST_TADV, ST_NEXTSH, ST_GAIN, ST_EMIT,
      ST_FIN
   } gsc_state_type;

   // shape coefficient j (0..16, centre at 8), Q12
   function automatic gsc_sample_type gsc_shape(input int s, input int j);
      int d;
      int v;
      d = (j > HALF_LEN) ? j - HALF_LEN : HALF_LEN - j;
      v = SHAPE_PEAK - d * (SHAPE_SLOPE + s * SHAPE_STEP);
      if (j < 0 || j >= SHAPE_LEN || v < 0)
         v = 0;
      return gsc_sample_type'(v);
   endfunction
endpackage
`default_nettype wire

// *** rtl/gsc_search_top.sv ***
// glottal-shape codebook search with gain quantization and excitation
`default_nettype none
module gsc_search_top (
   input  wire logic                          ref_clk,
   input  wire logic                          sys_rst,
   input  wire logic                          loadValid,
   input  wire logic [1:0]                    loadSel,
   input  wire logic [gsc_pkg::IDX_W-1:0]     loadIdx,
   input  wire gsc_pkg::gsc_sample_type       loadData,
   input  wire logic [gsc_pkg::LAG_W-1:0]     closedLoopPitchLag,
   input  wire logic                          startReq,
   output logic                               busy,
   output logic                               done,
   output logic [gsc_pkg::SHAPE_W-1:0]        shapeIdx,
   output logic [gsc_pkg::IDX_W-1:0]          position,
   output logic                               gainSign,
   output logic [gsc_pkg::GAIN_IDX_W-1:0]     glottalGainIndex,
   output logic                               lagSend,
   output logic                               excValid,
   output logic [gsc_pkg::IDX_W-1:0]          excIdx,
   output gsc_pkg::gsc_sample_type            excRaw,
   output gsc_pkg::gsc_sample_type            excFilt,
   output logic                               excShapePart
);
   import gsc_pkg::*;

   gsc_sample_type             tgt_q [SUB_LEN];
   gsc_sample_type             res_q [SUB_LEN];
   gsc_sample_type             imp_q [SUB_LEN];
   gsc_row_type                row_q [SUB_LEN];
   gsc_row_type                rowNext [SUB_LEN];
   gsc_state_type              state_q;
   logic [SHAPE_W-1:0]         shape_q;
   logic [IDX_W-1:0]           pos_q;
   logic [IDX_W-1:0]           peak_q;
   logic [SAMPLE_W-1:0]        peakAbs_q;
   logic [CNT_W-1:0]           n_q;
   logic [LAG_W-1:0]           lag_q;
   gsc_acc_type                corr_q;
   gsc_acc_type                en_q;
   logic [SHAPE_W-1:0]         bestShape_q;
   logic [IDX_W-1:0]           bestPos_q;
   gsc_acc_type                bestCorr_q;
   gsc_acc_type                bestEn_q;
   logic                       bestValid_q;
   logic                       lagSend_q;
   logic                       busy_q;
   logic                       done_q;
   logic [SHAPE_W-1:0]         shapeIdx_q;
   logic [IDX_W-1:0]           position_q;
   logic                       gainSign_q;
   logic [GAIN_IDX_W-1:0]      gainIdx_q;
   logic                       excValid_q;
   logic [IDX_W-1:0]           excIdx_q;
   gsc_sample_type             excRaw_q;
   gsc_sample_type             excFilt_q;
   logic                       excShapePart_q;
   gsc_acc_type                row0Sum;
   gsc_acc_type                tailInit;
   gsc_sample_type             coefK;
   logic                       inWin;
   logic                       better;
   logic [SAMPLE_W-1:0]        resAbs;
   logic [IDX_W-1:0]           tailX;
   logic [IDX_W-1:0]           tailAdd;
   logic [IDX_W-1:0]           nIdx;
   logic                       shapePart;
   gsc_acc_type                gainSigned;
   gsc_acc_type                qCur;
   gsc_acc_type                qLp;
   gsc_acc_type                vRaw;
   gsc_acc_type                vFilt;

   gsc_gain_if gainBus ();

   gsc_gain_quant quant (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .gain    (gainBus.quant)
   );

   assign gainBus.corr   = bestCorr_q;
   assign gainBus.energy = ACC_W'(bestEn_q);

   // shape centred on the chosen position, zero outside the subframe
   function automatic gsc_acc_type qAt(input int m, input int s,
                                       input int p);
      if (m < 0 || m >= SUB_LEN)
         return '0;
      return gsc_acc_type'(gsc_shape(s, m - p + HALF_LEN));
   endfunction

   assign nIdx    = IDX_W'(n_q);
   assign resAbs  = res_q[nIdx][SAMPLE_W-1] ? SAMPLE_W'(-res_q[nIdx])
                                           : SAMPLE_W'(res_q[nIdx]);
   assign coefK   = gsc_shape(int'(shape_q), HALF_LEN - int'(pos_q));
   assign tailX   = IDX_W'(int'(pos_q) - HALF_LEN + int'(n_q));
   assign tailAdd = IDX_W'(SUB_LEN + HALF_LEN - 1 - int'(pos_q));
   assign inWin   = (int'(pos_q) + SEARCH_SPAN >= int'(peak_q)) &&
                    (int'(pos_q) <= int'(peak_q) + SEARCH_SPAN);

   // position zero: one output sample per cycle, nine taps at most
   always_comb begin
      row0Sum = '0;
      for (int j = 0; j <= HALF_LEN; j++) begin
         if (int'(n_q) >= j)
            row0Sum = row0Sum + gsc_acc_type'(
               gsc_shape(int'(shape_q), j + HALF_LEN) *
               imp_q[IDX_W'(int'(n_q) - j)]);
      end
   end

   // next row from previous row, all samples in one cycle
   for (genvar g = 0; g < SUB_LEN; g++) begin : g_row
      gsc_acc_type prod;
      assign prod = gsc_acc_type'(coefK * imp_q[g]) >>> COEF_FRAC;
      if (g == 0) begin : g_first
         assign rowNext[g] = ZW'(prod);
      end else begin : g_rest
         assign rowNext[g] = row_q[g-1] + ZW'(prod);
      end
   end

   // last position: energy of the first half-length plus one samples
   always_comb begin
      tailInit = '0;
      for (int i = 0; i <= HALF_LEN; i++)
         tailInit = tailInit + gsc_acc_type'(row_q[i] * row_q[i]);
   end

   // strict greater keeps the earlier candidate on a tie
   always_comb begin
      logic signed [CMP_W-1:0] lhs;
      logic signed [CMP_W-1:0] rhs;
      lhs = '0;
      rhs = '0;
      lhs = CMP_W'(corr_q * corr_q) * CMP_W'(bestEn_q);
      rhs = CMP_W'(bestCorr_q * bestCorr_q) * CMP_W'(en_q);
      better = (en_q > 0) && (!bestValid_q || lhs > rhs);
   end

   always_comb begin
      gainSigned = gainBus.signBit ? gsc_acc_type'(gainBus.magnitude)
                                   : -gsc_acc_type'(gainBus.magnitude);
      qCur  = qAt(int'(n_q), int'(bestShape_q), int'(bestPos_q));
      qLp   = qAt(int'(n_q) - 1, int'(bestShape_q), int'(bestPos_q)) +
              (qCur <<< 1) +
              qAt(int'(n_q) + 1, int'(bestShape_q), int'(bestPos_q));
      vRaw  = (gainSigned * qCur) >>> COEF_FRAC;
      vFilt = (gainSigned * qLp) >>> (COEF_FRAC + 2);
      // second pulse region is left to the adaptive path
      shapePart = !(lagSend_q && int'(n_q) >= int'(lag_q));
   end

   // vector storage, loaded only between searches
   always_ff @(posedge ref_clk) begin
      if (loadValid && state_q == ST_IDLE) begin
         case (loadSel)
            SEL_TARGET:   tgt_q[loadIdx] <= loadData;
            SEL_RESIDUAL: res_q[loadIdx] <= loadData;
            SEL_IMPULSE:  imp_q[loadIdx] <= loadData;
            default:      ;
         endcase
      end
   end

   // working row
   always_ff @(posedge ref_clk) begin
      if (state_q == ST_ROW0)
         row_q[nIdx] <= ZW'(row0Sum >>> COEF_FRAC);
      else if (state_q == ST_ROWK)
         row_q <= rowNext;
   end

   // search sequencer
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_q     <= ST_IDLE;
         shape_q     <= '0;
         pos_q       <= '0;
         peak_q      <= '0;
         peakAbs_q   <= '0;
         n_q         <= '0;
         lag_q       <= '0;
         corr_q      <= '0;
         en_q        <= '0;
         bestShape_q <= '0;
         bestPos_q   <= '0;
         bestCorr_q  <= '0;
         bestEn_q    <= '0;
         bestValid_q <= 1'b0;
         lagSend_q   <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (startReq) begin
                  lag_q       <= closedLoopPitchLag;
                  bestValid_q <= 1'b0;
                  shape_q     <= '0;
                  peakAbs_q   <= '0;
                  peak_q      <= '0;
                  n_q         <= '0;
                  state_q     <= ST_PEAK;
               end
            end
            ST_PEAK: begin
               if (resAbs > peakAbs_q) begin
                  peakAbs_q <= resAbs;
                  peak_q    <= nIdx;
               end
               n_q <= n_q + 1'b1;
               if (int'(n_q) == SUB_LEN - 1) begin
                  n_q     <= '0;
                  state_q <= ST_ROW0;
               end
            end
            ST_ROW0: begin
               n_q <= n_q + 1'b1;
               if (int'(n_q) == SUB_LEN - 1) begin
                  pos_q   <= '0;
                  state_q <= ST_CHECK;
               end
            end
            ST_ROWK: state_q <= ST_CHECK;
            ST_CHECK: begin
               n_q     <= '0;
               corr_q  <= '0;
               en_q    <= '0;
               state_q <= inWin ? ST_SCORE : ST_ADV;
            end
            ST_SCORE: begin
               corr_q <= corr_q + gsc_acc_type'(row_q[nIdx] * tgt_q[nIdx]);
               en_q   <= en_q + gsc_acc_type'(row_q[nIdx] * row_q[nIdx]);
               n_q    <= n_q + 1'b1;
               if (int'(n_q) == SUB_LEN - 1)
                  state_q <= ST_CMP;
            end
            ST_CMP: begin
               if (better) begin
                  bestShape_q <= shape_q;
                  bestPos_q   <= pos_q;
                  bestCorr_q  <= corr_q;
                  bestEn_q    <= en_q;
                  bestValid_q <= 1'b1;
               end
               state_q <= (int'(pos_q) <= HALF_LEN) ? ST_ADV : ST_TADV;
            end
            ST_ADV: begin
               if (int'(pos_q) < HALF_LEN) begin
                  pos_q   <= pos_q + 1'b1;
                  state_q <= ST_ROWK;
               end else begin
                  pos_q   <= IDX_W'(SUB_LEN - 1);
                  state_q <= ST_TAILE;
               end
            end
            ST_TAILE: begin
               // row is now frozen; later rows are read as its delay
               if (int'(pos_q) == SUB_LEN - 1)
                  en_q <= tailInit;
               else
                  en_q <= en_q + gsc_acc_type'(row_q[tailAdd] *
                                               row_q[tailAdd]);
               corr_q  <= '0;
               n_q     <= '0;
               state_q <= inWin ? ST_TAILN : ST_TADV;
            end
            ST_TAILN: begin
               corr_q <= corr_q + gsc_acc_type'(tgt_q[tailX] *
                                                row_q[nIdx]);
               n_q    <= n_q + 1'b1;
               if (int'(n_q) == SUB_LEN + HALF_LEN - 1 - int'(pos_q))
                  state_q <= ST_CMP;
            end
            ST_TADV: begin
               if (int'(pos_q) == HALF_LEN + 1) begin
                  state_q <= ST_NEXTSH;
               end else begin
                  pos_q   <= pos_q - 1'b1;
                  state_q <= ST_TAILE;
               end
            end
            ST_NEXTSH: begin
               n_q <= '0;
               if (int'(shape_q) == NUM_SHAPES - 1) begin
                  state_q <= ST_GAIN;
               end else begin
                  shape_q <= shape_q + 1'b1;
                  state_q <= ST_ROW0;
               end
            end
            ST_GAIN: begin
               // two pulses only when the lag fits, lag must be short
               lagSend_q <= (int'(bestPos_q) + int'(lag_q) <
                             SUB_LEN + HALF_LEN) &&
                            (int'(lag_q) < SUB_LEN);
               n_q     <= '0;
               state_q <= ST_EMIT;
            end
            ST_EMIT: begin
               n_q <= n_q + 1'b1;
               if (int'(n_q) == SUB_LEN - 1)
                  state_q <= ST_FIN;
            end
            ST_FIN: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // excitation stream and results
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         busy_q         <= 1'b0;
         done_q         <= 1'b0;
         shapeIdx_q     <= '0;
         position_q     <= '0;
         gainSign_q     <= 1'b1;
         gainIdx_q      <= '0;
         excValid_q     <= 1'b0;
         excIdx_q       <= '0;
         excRaw_q       <= '0;
         excFilt_q      <= '0;
         excShapePart_q <= 1'b0;
      end else begin
         busy_q     <= (state_q == ST_IDLE) ? startReq : (state_q != ST_FIN);
         done_q     <= (state_q == ST_FIN);
         excValid_q <= (state_q == ST_EMIT);
         excIdx_q   <= nIdx;
         excShapePart_q <= shapePart;
         excRaw_q   <= shapePart ? SAMPLE_W'(vRaw) : '0;
         excFilt_q  <= shapePart ? SAMPLE_W'(vFilt) : '0;
         if (state_q == ST_FIN) begin
            shapeIdx_q <= bestShape_q;
            position_q <= bestPos_q;
            gainSign_q <= gainBus.signBit;
            gainIdx_q  <= gainBus.index;
         end
      end
   end

   assign busy             = busy_q;
   assign done             = done_q;
   assign shapeIdx         = shapeIdx_q;
   assign position         = position_q;
   assign gainSign         = gainSign_q;
   assign glottalGainIndex = gainIdx_q;
   assign lagSend          = lagSend_q;
   assign excValid         = excValid_q;
   assign excIdx           = excIdx_q;
   assign excRaw           = excRaw_q;
   assign excFilt          = excFilt_q;
   assign excShapePart     = excShapePart_q;

   a_done_single: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      done_q |-> !busy_q ##1 !done_q)
      else $error("done pulse longer than one cycle");

   a_done_after_stream: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      excValid_q && excIdx_q == 6'h3F |=> done_q)
      else $error("done not following last excitation sample");

   a_position_window: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      done_q |-> (int'(position_q) + SEARCH_SPAN >= int'(peak_q)) &&
                 (int'(position_q) <= int'(peak_q) + SEARCH_SPAN))
      else $error("chosen position outside peak window");

   a_sign_follows: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      done_q |-> gainSign_q == !bestCorr_q[ACC_W-1])
      else $error("sign bit does not match correlation sign");

   a_lag_flag: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      done_q |-> lagSend_q == ((int'(position_q) + int'(lag_q) <
                 SUB_LEN + HALF_LEN) && (int'(lag_q) < SUB_LEN)))
      else $error("pitch lag flag wrong");

   a_stream_length: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      excValid_q && excIdx_q == 6'h00 |->
         ##63 (excValid_q && excIdx_q == 6'h3F))
      else $error("excitation stream not 64 samples");

   a_second_pulse_zero: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      excValid_q && lagSend_q && int'(excIdx_q) >= int'(lag_q) |->
         excRaw_q == '0 && excFilt_q == '0 && !excShapePart_q)
      else $error("excitation past lag not cleared");

   a_tail_positions: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      state_q == ST_TAILE |-> int'(pos_q) > HALF_LEN &&
         $past(state_q) inside {ST_ADV, ST_TADV})
      else $error("tail stage entered at an early position");

   a_tail_energy_grows: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      state_q == ST_TAILE && int'(pos_q) < SUB_LEN - 1 |=>
         en_q >= $past(en_q))
      else $error("tail energy decreased");
endmodule
`default_nettype wire

// *** test/glottal_shape_codebook_search_bench.sv ***
// self-checking bench for the glottal-shape search
`default_nettype none
module glottal_shape_codebook_search_bench;
   import gsc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
   n_errors++; $display("[FAIL] %0t value mismatch", $time); end end

   typedef struct packed {
      logic [5:0] p;
      logic [15:0] a;
      logic [7:0] lag;
      logic lagExp;
   } gsc_case_type;

   logic ref_clk, sys_rst, startReq, busy, done, gainSign, lagSend;
   logic loadValid, excValid, excShapePart;
   logic [1:0] loadSel;
   logic [5:0] loadIdx, position, excIdx;
   logic [7:0] lag;
   logic [2:0] shapeIdx, gainIdx;
   gsc_sample_type loadData, excRaw, excFilt;
   int n_errors = 0;
   int tests_run = 0;
   // forward and tail positions, both signs and both sides of the lag limits
   gsc_case_type rows [5] = '{'{6'd20, 16'h2000, 8'd100, 1'b0},
      '{6'd40, 16'hE000, 8'd30, 1'b1}, '{6'd45, 16'h2000, 8'd30, 1'b0},
      '{6'd8, 16'hE000, 8'd63, 1'b1}, '{6'd5, 16'h2000, 8'd64, 1'b0}};

   gsc_search_top uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .loadValid(loadValid), .loadSel(loadSel), .loadIdx(loadIdx),
      .loadData(loadData), .closedLoopPitchLag(lag), .startReq(startReq),
      .busy(busy), .done(done), .shapeIdx(shapeIdx), .position(position),
      .gainSign(gainSign), .glottalGainIndex(gainIdx), .lagSend(lagSend),
      .excValid(excValid), .excIdx(excIdx), .excRaw(excRaw),
      .excFilt(excFilt), .excShapePart(excShapePart));
   gsc_encoder_model model (.ref_clk(ref_clk), .loadValid(loadValid),
      .loadSel(loadSel), .loadIdx(loadIdx), .loadData(loadData));

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic step;
      @(posedge ref_clk);
      #1;
   endtask

   task automatic report_and_stop;
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // narrowest shape has least energy, so shape 7 at the spike wins
   task automatic run(input gsc_case_type r, input bit inject);
      int n = 0;
      bit part;
      gsc_sample_type expRaw;
      // gain near one half lands on the fourth table entry
      expRaw = r.a[15] ? -GSC_GAIN_TABLE[3] : GSC_GAIN_TABLE[3];
      model.load_all(r.p, r.a);
      step;
      startReq = 1'b1;
      lag = r.lag;
      step;
      startReq = 1'b0;
      `CHK(busy, 1'b1)
      if (inject) begin
         step;
         startReq = 1'b1;
         step;
         startReq = 1'b0;
         model.load_all(50, 16'h7000);
      end
      for (int k = 0; k < 8000 && done !== 1'b1; k++) begin
         if (excValid === 1'b1) begin
            part = !(r.lagExp && n >= r.lag);
            `CHK(excIdx, n[5:0])
            `CHK(excShapePart, part)
            if (part && n == r.p) `CHK(excRaw, expRaw)
            if (part && n == r.p) `CHK(excFilt[15], r.a[15])
            n++;
         end
         step;
      end
      `CHK(done, 1'b1)
      `CHK(n, 64)
      `CHK(shapeIdx, 3'd7)
      `CHK(position, r.p)
      `CHK(gainSign, ~r.a[15])
      `CHK(gainIdx, 3'd3)
      `CHK(lagSend, r.lagExp)
      step;
      `CHK({done, busy}, 2'b00)
      $display("test done peak %0d", r.p);
   endtask

   initial begin
      sys_rst = 1'b1;
      startReq = 1'b0;
      lag = 8'h00;
      repeat (12) step;
      sys_rst = 1'b0;
      foreach (rows[i]) run(rows[i], 1'b0);
      // second start and fresh loads during a search must be ignored
      run(rows[0], 1'b1);
      model.load_all(20, 16'h2000);
      step;
      startReq = 1'b1;
      step;
      startReq = 1'b0;
      repeat (100) step;
      sys_rst = 1'b1;
      step;
      sys_rst = 1'b0;
      `CHK({busy, done, excValid, gainSign}, 4'b0001)
      $display("test done mid-run reset");
      run(rows[1], 1'b0);
      report_and_stop;
   end

   initial begin
      #500000;
      n_errors++;
      report_and_stop;
   end
endmodule
`default_nettype wire

// *** test/gsc_encoder_model.sv ***
// encoder-side model that loads subframe vectors into the search
`default_nettype none
module gsc_encoder_model (
   input  wire logic                 ref_clk,
   output logic                      loadValid,
   output logic [1:0]                loadSel,
   output logic [gsc_pkg::IDX_W-1:0] loadIdx,
   output gsc_pkg::gsc_sample_type   loadData
);
   import gsc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      loadValid = 1'b0;
      loadSel   = 2'h3;
      loadIdx   = 6'h00;
      loadData  = 16'h0000;
   end

   // target and residual carry one spike, impulse response is a unit
   // delta, so each filtered row is the bare shape
   task automatic load_all(input int peak, input gsc_sample_type amp);
      for (int s = 0; s < 3; s++) begin
         for (int i = 0; i < SUB_LEN; i++) begin
            @(posedge ref_clk);
            #1;
            loadValid = 1'b1;
            loadSel   = s[1:0];
            loadIdx   = i[IDX_W-1:0];
            loadData  = (s == 2) ? ((i == 0) ? 16'h1000 : 16'h0000)
                                 : ((i == peak) ? amp : 16'h0000);
         end
      end
      @(posedge ref_clk);
      #1;
      loadValid = 1'b0;
      // released data must not look like a live sample
      loadData  = ~loadData;
   endtask
endmodule
`default_nettype wire
